// ### src/rgw_gateway.sv
// Mode commands, link-quality reporting and transmit sequencing
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module rgw_gateway import rgw_pkg::*; #(
	parameter int P_SEC_CYC = SEC_CYC,
	parameter logic [7:0] P_PT_LONG = 8'h0c,
	parameter int P_SUBTELS = SUBTELS
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	input wire logic i_cmd_valid,
	input wire logic i_cmd_sop,
	input wire logic i_cmd_eop,
	input wire logic [7:0] i_cmd_byte,
	input wire logic [7:0] i_cmd_ptype,
	input wire logic [15:0] i_cmd_dlen,
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_code,
	output logic o_transparent,
	output logic o_sec_en,
	output logic o_chain_en,
	output logic o_lqt_active,
	input wire logic i_rx_valid,
	output logic o_rx_ready,
	input wire logic i_rx_pass,
	input wire logic i_rx_repeat,
	input wire logic [31:0] i_rx_id,
	input wire logic [7:0] i_rx_rssi_lo,
	input wire logic [7:0] i_rx_rssi_hi,
	input wire logic i_rx_rssi_known,
	input wire logic [7:0] i_rx_subtels,
	input wire logic [1:0] i_rx_level,
	input wire logic i_rx_level_known,
	output logic o_rpt_valid,
	output logic [RPT_W-1:0] o_rpt_data,
	input wire logic i_rpt_ready,
	input wire logic i_tx_req,
	input wire logic [7:0] i_tx_ptype,
	input wire logic i_tx_high_sec,
	output logic o_tx_ready,
	output logic o_tx_busy,
	output logic o_tx_from_rpt,
	output logic o_sec_start,
	input wire logic i_sec_done,
	output logic o_subtel_start,
	input wire logic i_subtel_done,
	output logic o_tx_done
);
	// Command capture
	logic [2:0] idx_reg; // Data bytes seen so far
	logic [7:0] code_reg; // Command code byte
	logic [7:0] val_reg; // Setting byte
	logic [15:0] tmo_in_reg; // Timeout field, high byte first
	logic [15:0] dlen_reg; // Declared data length
	logic common_reg; // Packet was a common command
	logic done_reg; // Packet ended last cycle
	logic is_tr; // Complete transparent command
	logic is_lq; // Complete link test command
	logic val_ok; // Setting byte is 0x00 or 0x01
	// Deferred apply
	logic apply_reg; // Apply setting this cycle
	logic kind_lq_reg; // Pending setting is link test
	// Mode state
	logic lqt_reg; // Reporting on
	logic [15:0] tmo_reg; // Seconds left, zero means endless
	logic [31:0] sec_cnt_reg; // One second divider
	logic sec_tick; // One cycle per second
	// Control register
	logic rep_en_reg; // Repeating enabled
	// Reporting path
	logic need_rpt;
	logic rx_take;
	logic [RPT_W-1:0] rpt;
	// Transmit
	rgw_tx_e tx_state_reg;
	logic hs_reg; // Destination wants high security
	logic rpend_reg; // Repeat request waiting
	logic [3:0] sent_reg; // Subtelegrams sent
	logic ptype_ok;
	logic host_go;

	rgw_stream_if #(.W(RPT_W)) fin ();
	rgw_stream_if #(.W(RPT_W)) fout ();

	// Count the data field bytes and keep the fields we need
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			idx_reg <= '0;
			code_reg <= '0;
			val_reg <= '0;
			tmo_in_reg <= '0;
			dlen_reg <= '0;
			common_reg <= 1'b0;
		end else if (i_cmd_valid) begin
			if (i_cmd_sop) begin
				idx_reg <= IDX_VAL;
				code_reg <= i_cmd_byte;
				dlen_reg <= i_cmd_dlen;
				common_reg <= (i_cmd_ptype == PT_COMMON);
			end else begin
				// Byte position picks the field
				case (idx_reg)
					IDX_VAL: val_reg <= i_cmd_byte;
					IDX_THI: tmo_in_reg[15:8] <= i_cmd_byte;
					IDX_TLO: tmo_in_reg[7:0] <= i_cmd_byte;
					default: ;
				endcase
				// Saturate so long packets never wrap into a match
				if (idx_reg != IDX_MAX) begin
					idx_reg <= idx_reg + 1'b1;
				end
			end
		end
	end

	// End of packet marker, decode happens one cycle later
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= i_cmd_valid & i_cmd_eop;
		end
	end

	// Length must agree with both the header and the bytes seen
	assign is_tr = done_reg & common_reg & (code_reg == CMD_TRANSP) &
		(dlen_reg == LEN_TRANSP) & (16'(idx_reg) == LEN_TRANSP);
	assign is_lq = done_reg & common_reg & (code_reg == CMD_LQT) &
		(dlen_reg == LEN_LQT) & (16'(idx_reg) == LEN_LQT);
	assign val_ok = (val_reg == SET_OFF) | (val_reg == SET_ON);

	// Answer first; the setting lands one cycle behind the answer
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_rsp_valid <= 1'b0;
			o_rsp_code <= RSP_OK;
			apply_reg <= 1'b0;
			kind_lq_reg <= 1'b0;
		end else begin
			o_rsp_valid <= is_tr | is_lq;
			apply_reg <= (is_tr | is_lq) & val_ok;
			if (is_tr | is_lq) begin
				o_rsp_code <= val_ok ? RSP_OK : RSP_BAD;
				kind_lq_reg <= is_lq;
			end
		end
	end

	// Transparent mode flag
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_transparent <= 1'b0;
		end else if (apply_reg && !kind_lq_reg) begin
			o_transparent <= (val_reg == SET_ON);
		end
	end

	// Only security and chaining follow transparent mode
	assign o_sec_en = ~o_transparent;
	assign o_chain_en = ~o_transparent;

	// Second divider runs only while a timeout is counting
	assign sec_tick = lqt_reg & (tmo_reg != '0) &
		(sec_cnt_reg == 32'(P_SEC_CYC - 1));
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst || apply_reg || sec_tick) begin
			sec_cnt_reg <= '0;
		end else if (lqt_reg && tmo_reg != '0) begin
			sec_cnt_reg <= sec_cnt_reg + 32'h1;
		end
	end

	// Link test enable and timeout; a new command restarts the count
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			lqt_reg <= 1'b0;
			tmo_reg <= '0;
		end else if (apply_reg && kind_lq_reg) begin
			lqt_reg <= (val_reg == SET_ON);
			tmo_reg <= tmo_in_reg;
		end else if (sec_tick) begin
			tmo_reg <= tmo_reg - 16'h1;
			if (tmo_reg == 16'h1) begin
				lqt_reg <= 1'b0;
			end
		end
	end
	assign o_lqt_active = lqt_reg;

	// Signed dBm to report code; -128 cannot be shown, so unknown
	function automatic logic [7:0] rssi_code(input logic [7:0] d,
		input logic k);
		if (!k || d == RSSI_OOR) begin
			return RSSI_UNK;
		end
		return RSSI_ZERO - d;
	endfunction

	// Assemble the report word from the received telegram
	always_comb begin
		rpt = '0;
		rpt[F_TYPE +: 8] = RPT_TYPE;
		rpt[F_ID +: 32] = i_rx_id;
		rpt[F_LO +: 8] = rssi_code(i_rx_rssi_lo, i_rx_rssi_known);
		rpt[F_HI +: 8] = rssi_code(i_rx_rssi_hi, i_rx_rssi_known);
		// Zero count means the receiver could not tell
		if (i_rx_subtels == '0) begin
			rpt[F_CNT +: 4] = CNT_UNK;
		end else if (i_rx_subtels >= 8'(CNT_SAT)) begin
			rpt[F_CNT +: 4] = CNT_SAT;
		end else begin
			rpt[F_CNT +: 4] = i_rx_subtels[3:0];
		end
		// Levels above two have no code and read as unknown
		if (!i_rx_level_known || i_rx_level > LVL_MAX) begin
			rpt[F_LVL +: 4] = LVL_UNK;
		end else begin
			rpt[F_LVL +: 4] = {2'b00, i_rx_level};
		end
	end

	// Only filtered telegrams report; a full FIFO stalls the receiver
	assign need_rpt = i_rx_pass & lqt_reg;
	assign fin.valid = i_rx_valid & need_rpt;
	assign fin.data = rpt;
	assign o_rx_ready = ~need_rpt | fin.ready;
	assign rx_take = i_rx_valid & o_rx_ready;

	rgw_fifo #(.W(RPT_W), .D(FIFO_DEPTH)) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.s_in(fin),
		.s_out(fout)
	);
	assign o_rpt_valid = fout.valid;
	assign o_rpt_data = fout.data;
	assign fout.ready = i_rpt_ready;

	// Control register write
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			rep_en_reg <= 1'b0;
		end else if (i_reg_wr && i_reg_addr == A_CTRL) begin
			rep_en_reg <= i_reg_wdata[C_REP];
		end
	end

	// Register read, unmapped words read zero
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_reg_rdata <= '0;
		end else if (i_reg_rd) begin
			o_reg_rdata <= '0;
			case (i_reg_addr)
				A_CTRL: o_reg_rdata[C_REP] <= rep_en_reg;
				A_STAT: begin
					o_reg_rdata[S_TRANSP] <= o_transparent;
					o_reg_rdata[S_LQT] <= lqt_reg;
					o_reg_rdata[S_BUSY] <= o_tx_busy;
					o_reg_rdata[S_RPEND] <= rpend_reg;
				end
				A_TMO: o_reg_rdata[15:0] <= tmo_reg;
				default: ;
			endcase
		end
	end

	// Three packet types start a transmission
	assign ptype_ok = (i_tx_ptype == PT_GEN1) |
		(i_tx_ptype == PT_GEN2) | (i_tx_ptype == P_PT_LONG);
	assign o_tx_ready = (tx_state_reg == TX_IDLE);
	assign host_go = i_tx_req & o_tx_ready & ptype_ok;
	assign o_tx_busy = ~o_tx_ready;

	// Repeat request waits here; a new one wins over the clear
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			rpend_reg <= 1'b0;
		end else if (rx_take && i_rx_repeat && rep_en_reg) begin
			rpend_reg <= 1'b1;
		end else if (o_tx_ready && !host_go) begin
			rpend_reg <= 1'b0;
		end
	end

	// Transmit sequencer: optional security, then the subtelegrams
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			tx_state_reg <= TX_IDLE;
			hs_reg <= 1'b0;
			o_tx_from_rpt <= 1'b0;
			sent_reg <= '0;
			o_sec_start <= 1'b0;
			o_subtel_start <= 1'b0;
			o_tx_done <= 1'b0;
		end else begin
			o_sec_start <= 1'b0;
			o_subtel_start <= 1'b0;
			o_tx_done <= 1'b0;
			case (tx_state_reg)
				TX_IDLE: begin
					sent_reg <= '0;
					// Host has priority; repeats are sent as received
					if (host_go) begin
						o_tx_from_rpt <= 1'b0;
						hs_reg <= i_tx_high_sec;
						if (i_tx_high_sec && !o_transparent) begin
							tx_state_reg <= TX_SEC;
							o_sec_start <= 1'b1;
						end else begin
							tx_state_reg <= TX_SEND;
						end
					end else if (rpend_reg) begin
						o_tx_from_rpt <= 1'b1;
						hs_reg <= 1'b0;
						tx_state_reg <= TX_SEND;
					end
				end
				TX_SEC: begin
					if (i_sec_done) begin
						tx_state_reg <= TX_SEND;
					end
				end
				TX_SEND: begin
					o_subtel_start <= 1'b1;
					tx_state_reg <= TX_WAIT;
				end
				TX_WAIT: begin
					if (i_subtel_done) begin
						sent_reg <= sent_reg + 4'h1;
						// Redundant copies until the set is complete
						if (sent_reg == 4'(P_SUBTELS - 1)) begin
							o_tx_done <= 1'b1;
							tx_state_reg <= TX_IDLE;
						end else begin
							tx_state_reg <= TX_SEND;
						end
					end
				end
				default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	sequence s_cmd_end;
		(is_tr | is_lq) ##1 o_rsp_valid;
	endsequence

	rsp_first_a: assert property (
		(is_tr | is_lq) |=> o_rsp_valid ##1 !o_rsp_valid)
		else $error("no single response after command");
	apply_late_a: assert property (
		$changed(o_transparent) |-> $past(o_rsp_valid) && !o_rsp_valid)
		else $error("transparent changed before response");
	tr_set_a: assert property (
		s_cmd_end ##0 (kind_lq_reg == 1'b0 && val_reg == SET_ON)
		|=> o_transparent)
		else $error("transparent not enabled");
	lq_set_a: assert property (
		s_cmd_end ##0 (kind_lq_reg && val_reg == SET_OFF)
		|=> !lqt_reg)
		else $error("link test not disabled");
	transp_gate_a: assert property (
		o_transparent |-> !o_sec_en && !o_chain_en)
		else $error("security active in transparent mode");
	sec_skip_a: assert property (
		o_sec_start |-> hs_reg && !$past(o_transparent))
		else $error("security started without need");
	tmo_end_a: assert property (
		(sec_tick && tmo_reg == 16'h1) |=> !lqt_reg && tmo_reg == '0)
		else $error("timeout did not stop reporting");
	tmo_zero_a: assert property (
		(lqt_reg && tmo_reg == '0 && !apply_reg) |=> lqt_reg)
		else $error("endless reporting stopped");
	rpt_gate_a: assert property (
		fin.valid |-> i_rx_pass && lqt_reg &&
		fin.data[F_TYPE +: 8] == RPT_TYPE)
		else $error("report without filter pass or mode");
	cnt_sat_a: assert property (
		(fin.valid && i_rx_subtels > 8'(CNT_SAT)) |->
		fin.data[F_CNT +: 4] == CNT_SAT)
		else $error("count not saturated");
	rssi_zero_a: assert property (
		(fin.valid && i_rx_rssi_known && i_rx_rssi_lo == '0) |->
		fin.data[F_LO +: 8] == RSSI_ZERO)
		else $error("rssi code wrong");
	tx_enter_a: assert property (
		host_go |=> o_tx_busy)
		else $error("host request not taken");
	subtel_cnt_a: assert property (
		o_tx_done |-> sent_reg == 4'(P_SUBTELS))
		else $error("wrong subtelegram count");
endmodule

// ### src/rgw_pkg.sv
// Shared constants and types of the radio gateway command block
package rgw_pkg;
	// Host serial protocol packet types
	localparam logic [7:0] PT_COMMON = 8'h05;
	localparam logic [7:0] PT_GEN1 = 8'h01;
	localparam logic [7:0] PT_GEN2 = 8'h0a;
	// Mode command codes and data field lengths
	localparam logic [7:0] CMD_TRANSP = 8'h3e;
	localparam logic [7:0] CMD_LQT = 8'h3a;
	localparam logic [15:0] LEN_TRANSP = 16'h0002;
	localparam logic [15:0] LEN_LQT = 16'h0004;
	// Setting values
	localparam logic [7:0] SET_OFF = 8'h00;
	localparam logic [7:0] SET_ON = 8'h01;
	// Response codes
	localparam logic [7:0] RSP_OK = 8'h00;
	localparam logic [7:0] RSP_BAD = 8'h03;
	// Report layout
	localparam int RPT_W = 64;
	localparam logic [7:0] RPT_TYPE = 8'h0a;
	localparam int F_TYPE = 0;
	localparam int F_ID = 8;
	localparam int F_LO = 40;
	localparam int F_HI = 48;
	localparam int F_CNT = 56;
	localparam int F_LVL = 60;
	// Report field codes
	localparam logic [7:0] RSSI_ZERO = 8'h7f;
	localparam logic [7:0] RSSI_UNK = 8'hff;
	localparam logic [7:0] RSSI_OOR = 8'h80;
	localparam logic [3:0] CNT_UNK = 4'h0;
	localparam logic [3:0] CNT_SAT = 4'hf;
	localparam logic [3:0] LVL_UNK = 4'hf;
	localparam logic [1:0] LVL_MAX = 2'h2;
	// Buffering and transmit
	localparam int FIFO_DEPTH = 4;
	localparam int SUBTELS = 3;
	// Timing: one second tick at the core clock
	localparam int CLK_NS = 10;
	localparam int SEC_S = 1;
	localparam int SEC_CYC = SEC_S * 1000000000 / CLK_NS;
	// Register map (word index)
	localparam logic [1:0] A_CTRL = 2'h0;
	localparam logic [1:0] A_STAT = 2'h1;
	localparam logic [1:0] A_TMO = 2'h2;
	localparam int C_REP = 0;
	localparam int S_TRANSP = 0;
	localparam int S_LQT = 1;
	localparam int S_BUSY = 2;
	localparam int S_RPEND = 3;
	// Command data byte positions
	localparam logic [2:0] IDX_VAL = 3'h1;
	localparam logic [2:0] IDX_THI = 3'h2;
	localparam logic [2:0] IDX_TLO = 3'h3;
	localparam logic [2:0] IDX_MAX = 3'h7;
	// Transmit sequencer states
	typedef enum logic [1:0] {TX_IDLE, TX_SEC, TX_SEND, TX_WAIT} rgw_tx_e;
endpackage

// ### src/rgw_stream_if.sv
// Valid/ready word stream between the block's modules
`timescale 1ns/100ps
interface rgw_stream_if #(parameter int W = 64);
	logic valid; // Word offered
	logic ready; // Word taken
	logic [W-1:0] data; // Word
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// ### src/rgw_fifo.sv
// Small register FIFO for link-quality reports
`timescale 1ns/100ps
module rgw_fifo #(
	parameter int W = 64,
	parameter int D = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	rgw_stream_if.snk s_in,
	rgw_stream_if.src s_out
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_reg [D]; // Storage words
	logic [AW-1:0] wp_reg; // Write pointer
	logic [AW-1:0] rp_reg; // Read pointer
	logic [AW:0] cnt_reg; // Fill level
	logic push;
	logic pop;

	// Full and empty come straight from the fill level
	assign s_in.ready = (cnt_reg != (AW+1)'(D));
	assign s_out.valid = (cnt_reg != '0);
	assign s_out.data = mem_reg[rp_reg];
	assign push = s_in.valid & s_in.ready;
	assign pop = s_out.valid & s_out.ready;

	// Storage write, no reset needed for data
	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem_reg[wp_reg] <= s_in.data;
		end
	end

	// Pointers and level
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wp_reg <= (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Never more than depth words held
	fifo_level_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		cnt_reg <= (AW+1)'(D))
		else $error("fifo level above depth");
endmodule

// ### tb/rgw_far_model.sv
// Host and radio side model facing the gateway block
`timescale 1ns/100ps
module rgw_far_model (
	input wire logic i_clk_sys,
	input wire logic i_sec_start,
	input wire logic i_subtel_start,
	output logic o_cmd_valid,
	output logic o_cmd_sop,
	output logic o_cmd_eop,
	output logic [7:0] o_cmd_byte,
	output logic [7:0] o_cmd_ptype,
	output logic [15:0] o_cmd_dlen,
	output logic o_sec_done,
	output logic o_subtel_done
);
	int dly = 1; // Radio answer delay, the bench may slow it
	logic sec_q; // Step being answered is the security one

	// Host idles with the command lines quiet
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_sop = 1'b0;
		o_cmd_eop = 1'b0;
		o_cmd_byte = 8'h00;
		o_cmd_ptype = 8'h00;
		o_cmd_dlen = 16'h0000;
	end

	// One packet: dl data bytes from the top of pk, one a cycle
	task automatic send(input logic [7:0] pt, input logic [15:0] dl,
		input logic [31:0] pk);
		for (int i = 0; i < dl; i++) begin
			@(posedge i_clk_sys);
			o_cmd_valid <= 1'b1;
			o_cmd_sop <= (i == 0);
			o_cmd_eop <= (i == dl - 1);
			o_cmd_byte <= pk[31 - 8 * i -: 8];
			o_cmd_ptype <= pt;
			o_cmd_dlen <= dl;
		end
		@(posedge i_clk_sys);
		o_cmd_valid <= 1'b0;
		o_cmd_sop <= 1'b0;
		o_cmd_eop <= 1'b0;
		// Released lane must not look like the last byte
		o_cmd_byte <= ~o_cmd_byte;
	endtask

	// Security engine and radio finish each step after dly edges
	initial begin
		o_sec_done = 1'b0;
		o_subtel_done = 1'b0;
		forever begin
			@(posedge i_clk_sys);
			if (i_sec_start === 1'b1 || i_subtel_start === 1'b1) begin
				sec_q = i_sec_start;
				repeat (dly) @(posedge i_clk_sys);
				o_sec_done <= sec_q;
				o_subtel_done <= ~sec_q;
				@(posedge i_clk_sys);
				o_sec_done <= 1'b0;
				o_subtel_done <= 1'b0;
			end
		end
	end
endmodule

// ### tb/rgw_gateway_tb.sv
// Self-checking testbench of the radio gateway command block
`timescale 1ns/100ps
module rgw_gateway_tb import rgw_pkg::*; ;
	logic i_clk_sys, i_nrst; // Core clock, reset
	logic [1:0] i_reg_addr; // Register bus
	logic [31:0] i_reg_wdata, o_reg_rdata;
	logic i_reg_wr, i_reg_rd;
	logic i_cmd_valid, i_cmd_sop, i_cmd_eop; // Host command bytes
	logic [7:0] i_cmd_byte, i_cmd_ptype, o_rsp_code;
	logic [15:0] i_cmd_dlen;
	logic o_rsp_valid, o_transparent, o_sec_en, o_chain_en, o_lqt_active;
	logic i_rx_valid, o_rx_ready, i_rx_pass, i_rx_repeat; // Received
	logic [31:0] i_rx_id;
	logic [7:0] i_rx_rssi_lo, i_rx_rssi_hi, i_rx_subtels;
	logic i_rx_rssi_known, i_rx_level_known;
	logic [1:0] i_rx_level;
	logic o_rpt_valid, i_rpt_ready; // Report stream
	logic [RPT_W-1:0] o_rpt_data;
	logic i_tx_req, i_tx_high_sec, o_tx_ready, o_tx_busy; // Transmit
	logic [7:0] i_tx_ptype;
	logic o_tx_from_rpt, o_sec_start, i_sec_done;
	logic o_subtel_start, i_subtel_done, o_tx_done;
	int error_cnt = 0; // Mismatches
	int n_checks = 0; // Comparisons
	int n_sub = 0, n_sec = 0, n_rpt = 0; // Start pulses, and busy cycles of a repeat, of current transfer
	logic [63:0] q[$]; // Reports expected, oldest first
	logic [7:0] pts[3] = '{PT_GEN1, PT_GEN2, 8'h0c}; // Transmit types
	logic [7:0] bpt[3] = '{8'h06, PT_COMMON, PT_COMMON}; // Malformed
	logic [31:0] bpk[3] = '{32'h3e010000, 32'h3a010000, 32'h3f010000};

	// Short second so timeouts run in a few dozen cycles
	rgw_gateway #(.P_SEC_CYC(20), .P_PT_LONG(8'h0c), .P_SUBTELS(3))
		rgw_gateway_inst (
		.i_clk_sys, .i_nrst, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
		.i_reg_rd, .o_reg_rdata, .i_cmd_valid, .i_cmd_sop, .i_cmd_eop,
		.i_cmd_byte, .i_cmd_ptype, .i_cmd_dlen, .o_rsp_valid,
		.o_rsp_code, .o_transparent, .o_sec_en, .o_chain_en,
		.o_lqt_active, .i_rx_valid, .o_rx_ready, .i_rx_pass,
		.i_rx_repeat, .i_rx_id, .i_rx_rssi_lo, .i_rx_rssi_hi,
		.i_rx_rssi_known, .i_rx_subtels, .i_rx_level,
		.i_rx_level_known, .o_rpt_valid, .o_rpt_data, .i_rpt_ready,
		.i_tx_req, .i_tx_ptype, .i_tx_high_sec, .o_tx_ready, .o_tx_busy,
		.o_tx_from_rpt, .o_sec_start, .i_sec_done, .o_subtel_start,
		.i_subtel_done, .o_tx_done
	);

	// Host and radio stand-in
	rgw_far_model rgw_far_model_inst (
		.i_clk_sys, .i_sec_start(o_sec_start),
		.i_subtel_start(o_subtel_start), .o_cmd_valid(i_cmd_valid),
		.o_cmd_sop(i_cmd_sop), .o_cmd_eop(i_cmd_eop),
		.o_cmd_byte(i_cmd_byte), .o_cmd_ptype(i_cmd_ptype),
		.o_cmd_dlen(i_cmd_dlen), .o_sec_done(i_sec_done),
		.o_subtel_done(i_subtel_done)
	);

	// 100 MHz clock
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	// Start pulse and repeat busy-cycle counters, cleared by the bench before each transfer
	always @(posedge i_clk_sys) begin
		if (o_subtel_start === 1'b1) n_sub <= n_sub + 1;
		if (o_sec_start === 1'b1) n_sec <= n_sec + 1;
		if (o_tx_from_rpt === 1'b1 && o_tx_busy === 1'b1) n_rpt <= n_rpt + 1;
	end

	task automatic chk(input string nm, input logic [63:0] e, g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Flags the bench waits on or watches
	function automatic logic flag(input int k);
		case (k)
			0: return o_rsp_valid;
			1: return o_rpt_valid;
			2: return o_tx_done;
			3: return ~o_lqt_active;
			default: return o_tx_busy;
		endcase
	endfunction

	// Bounded wait; running out ends the run as a failure
	task automatic wt(input int k, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk_sys);
			#1;
			if (flag(k) === 1'b1) return;
		end
		chk("wait", 1, 0);
		finish_test();
	endtask

	// Flag must stay low for n cycles
	task automatic quiet(input int k, input int n, input string nm);
		repeat (n) @(posedge i_clk_sys) #1 chk(nm, 0, flag(k));
	endtask

	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask

	// Read data appear in the cycle after the strobe and hold until the next read
	task automatic rd(input logic [1:0] a, input logic [31:0] e,
		input string nm);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b0;
		#1 chk(nm, e, o_reg_rdata);
	endtask

	task automatic cmd(input logic [15:0] dl, input logic [31:0] pk,
		input logic [7:0] code);
		rgw_far_model_inst.send(PT_COMMON, dl, pk);
		wt(0, 6);
		chk("rsp_code", code, o_rsp_code);
	endtask

	task automatic clr();
		n_sub = 0;
		n_sec = 0;
		n_rpt = 0;
	endtask

	// Host transmit request; es is the security steps expected
	task automatic tx(input logic [7:0] pt, input logic hs, input int es);
		clr();
		@(posedge i_clk_sys);
		i_tx_req <= 1'b1;
		i_tx_ptype <= pt;
		i_tx_high_sec <= hs;
		@(posedge i_clk_sys);
		i_tx_req <= 1'b0;
		i_tx_ptype <= ~pt;
		#1 chk("tx_busy", 1, o_tx_busy);
		wt(2, 200);
		chk("subtels", 3, n_sub);
		chk("sec_steps", es, n_sec);
	endtask

	// Received telegram; f is {known, pass, repeat, report expected}
	task automatic rx(input logic [31:0] id, input logic [7:0] lo, hi,
		st, input logic [1:0] lv, input logic [3:0] f);
		logic [7:0] lc, hc;
		lc = f[3] ? 8'h7f - lo : 8'hff;
		hc = f[3] ? 8'h7f - hi : 8'hff;
		if (f[0]) q.push_back({f[3] ? {2'b00, lv} : 4'hf,
			st > 8'd15 ? 4'hf : st[3:0], hc, lc, id, 8'h0a});
		@(posedge i_clk_sys);
		i_rx_valid <= 1'b1;
		i_rx_id <= id;
		i_rx_rssi_lo <= lo;
		i_rx_rssi_hi <= hi;
		i_rx_subtels <= st;
		i_rx_level <= lv;
		{i_rx_rssi_known, i_rx_level_known} <= {2{f[3]}};
		{i_rx_pass, i_rx_repeat} <= f[2:1];
		// Held until taken; a full buffer makes us give up
		for (int i = 0; i < 4; i++) begin
			@(posedge i_clk_sys);
			if (o_rx_ready === 1'b1) break;
		end
		i_rx_valid <= 1'b0;
		i_rx_id <= ~id;
	endtask

	// Compare the head report with the oldest expectation, then take it
	task automatic pop();
		wt(1, 10);
		chk("report", q.pop_front(), o_rpt_data);
		@(posedge i_clk_sys);
		i_rpt_ready <= 1'b1;
		@(posedge i_clk_sys);
		i_rpt_ready <= 1'b0;
	endtask

	initial begin
		i_nrst = 1'b0;
		{i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd} = 36'h0;
		{i_rx_valid, i_rx_pass, i_rx_repeat, i_rx_rssi_known} = 4'h0;
		{i_rx_id, i_rx_rssi_lo, i_rx_rssi_hi, i_rx_subtels} = 56'h0;
		{i_rx_level, i_rx_level_known, i_rpt_ready} = 4'h0;
		{i_tx_req, i_tx_high_sec, i_tx_ptype} = 10'h0;
		repeat (20) @(posedge i_clk_sys);
		i_nrst <= 1'b1;
		#1 chk("reset_outs", 7'b0110101, {o_transparent, o_sec_en,
			o_chain_en, o_lqt_active, o_tx_ready, o_rpt_valid, o_rx_ready});
		// Status is read-only, word 3 is unmapped
		wr(A_STAT, 32'hffffffff);
		wr(2'h3, 32'hffffffff);
		rd(A_STAT, 32'h0, "status");
		rd(2'h3, 32'h0, "unmapped");
		// Wrong type, wrong length, unknown code: silence
		foreach (bpt[i]) begin
			rgw_far_model_inst.send(bpt[i], LEN_TRANSP, bpk[i]);
			quiet(0, 6, "no_rsp");
		end
		chk("modes", 2'b00, {o_transparent, o_lqt_active});
		// Transparent on: answered first, applied a cycle later
		rgw_far_model_inst.send(PT_COMMON, LEN_TRANSP, 32'h3e010000);
		wt(0, 6);
		chk("rsp_code", RSP_OK, o_rsp_code);
		chk("early_mode", 0, o_transparent);
		@(posedge i_clk_sys);
		#1 chk("transp_on", 3'b100, {o_transparent, o_sec_en, o_chain_en});
		rd(A_STAT, 32'h1, "status");
		cmd(LEN_TRANSP, 32'h3e020000, RSP_BAD);
		repeat (2) @(posedge i_clk_sys);
		#1 chk("transp_kept", 1, o_transparent);
		tx(PT_GEN1, 1'b1, 0);
		cmd(LEN_TRANSP, 32'h3e000000, RSP_OK);
		@(posedge i_clk_sys);
		#1 chk("transp_off", 3'b011, {o_transparent, o_sec_en, o_chain_en});
		// Every transmit type secured, then a slow plain one
		foreach (pts[i]) tx(pts[i], 1'b1, 1);
		rgw_far_model_inst.dly = 5;
		tx(PT_GEN2, 1'b0, 0);
		rgw_far_model_inst.dly = 1;
		// A command packet type starts no transmission
		@(posedge i_clk_sys);
		i_tx_req <= 1'b1;
		i_tx_ptype <= PT_COMMON;
		quiet(4, 3, "tx_idle");
		i_tx_req <= 1'b0;
		// Repeat only once repeating is enabled, without security
		rx(32'h0badf00d, 8'hc4, 8'hc4, 8'd3, 2'd0, 4'b1010);
		quiet(4, 4, "no_repeat");
		wr(A_CTRL, 32'h1);
		rd(A_CTRL, 32'h1, "ctrl");
		clr();
		rx(32'h0badf00d, 8'hc4, 8'hc4, 8'd3, 2'd0, 4'b1010);
		wt(2, 200);
		chk("repeat_tx", 3'b111, {n_rpt > 0, n_sub == 3, n_sec == 0});
		wr(A_CTRL, 32'h0);
		// Reporting on; the far side stalls until the buffer refuses
		cmd(LEN_LQT, 32'h3a010032, RSP_OK);
		@(posedge i_clk_sys);
		#1 chk("lqt_on", 1, o_lqt_active);
		rd(A_TMO, 32'h32, "tmo_left");
		rd(A_STAT, 32'h2, "status_lqt");
		rx(32'h01020304, 8'hc4, 8'hd8, 8'd2, 2'd0, 4'b1000);
		rx(32'h11223344, 8'hc4, 8'hd8, 8'd3, 2'd0, 4'b1101);
		rx(32'ha5a5a5a5, 8'h00, 8'h05, 8'd20, 2'd2, 4'b1101);
		rx(32'h5a5a5a5a, 8'h10, 8'h20, 8'd0, 2'd1, 4'b0101);
		rx(32'hfedcba98, 8'h81, 8'h7f, 8'd15, 2'd1, 4'b1101);
		rx(32'h77777777, 8'hc4, 8'hc4, 8'd1, 2'd0, 4'b1100);
		#1 chk("rx_full", 0, o_rx_ready);
		while (q.size() > 0) pop();
		quiet(1, 2, "drained");
		// Zero timeout never expires; disable turns it off
		cmd(LEN_LQT, 32'h3a010000, RSP_OK);
		repeat (100) @(posedge i_clk_sys);
		#1 chk("lqt_stays", 1, o_lqt_active);
		cmd(LEN_LQT, 32'h3a000000, RSP_OK);
		@(posedge i_clk_sys);
		#1 chk("lqt_off", 0, o_lqt_active);
		rx(32'h12345678, 8'hc4, 8'hc4, 8'd1, 2'd0, 4'b1100);
		quiet(1, 3, "no_report");
		// Two second timeout ends reporting by itself
		cmd(LEN_LQT, 32'h3a010002, RSP_OK);
		repeat (15) @(posedge i_clk_sys);
		#1 chk("lqt_early", 1, o_lqt_active);
		wt(3, 60);
		finish_test();
	end
endmodule
